// [hdl/dual_rgb_input.sv]
// dual parallel rgb video input: two pixel ports plus an optional third clock
// assumes each port's inputs are launched on that port's pixel clock, and that
// pixel clocks run well below a quarter of clk so each word is seen in clk
//
// Notes on behaviour
// - each of the two ports takes one 24-bit pixel per pixel clock in video mode.
// - channels a, b and c each carry one colour with 8 significant bits in a 10-bit bus.
// - sources of 8 bits or fewer drive the upper channel bits, and colour is taken from them.
// - every data, sync and valid input of a port is sampled on that port's own pixel clock.
// - an optional third pixel clock input is provided beside the two port clocks.
// - the a, b and c channels of each port may be reassigned to colours by configuration.
// - a frame interval with no new data raises frame_repeat_reg at the next frame sync, once a data frame has been seen.
`timescale 1ns/10ps

module rgb_port_rx
    import dual_rgb_pkg::*;
(
    // system side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [dual_rgb_pkg::MAP_W-1:0] colour_map,
    // pixel side
    input wire logic pclk,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] chan_a,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] chan_b,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] chan_c,
    input wire logic frame_sync,
    input wire logic line_sync,
    input wire logic data_valid,
    // received stream
    output dual_rgb_pkg::pixel_t pixel_reg,
    output logic pixel_valid_reg,
    output logic first_in_line_reg,
    output logic first_in_frame_reg,
    output logic frame_start_reg,
    output logic frame_repeat_reg
);
    // pick the channel named by a select, upper bits only
    function automatic logic [COLOUR_W-1:0] pick(input logic [SEL_W-1:0] sel,
                                                 input chan_t a, input chan_t b,
                                                 input chan_t c);
        chan_t w;
        w = (sel == SEL_B) ? b : (sel == SEL_C) ? c : a;
        return w[CHAN_W-1:COLOUR_LSB];
    endfunction

    // ------------------------------------------------------------------
    // pixel clock domain
    // ------------------------------------------------------------------
    logic prst_s1, prst_n_p;
    logic [MAP_W-1:0] map_s1, map_s2, map_s3, map_p;
    chan_t a_q, b_q, c_q;
    logic vs_q, hs_q, dv_q, vs_d, hs_d;
    logic sof_pend, sol_pend;
    pixel_t hold_pix;
    logic hold_sof, hold_sol, hold_tgl, frame_tgl;

    // reset brought onto the pixel clock
    always_ff @(posedge pclk) begin
        prst_s1 <= rst_n;
        prst_n_p <= prst_s1;
    end

    // map is quasi-static; adopted only once two samples agree
    always_ff @(posedge pclk) begin
        map_s1 <= colour_map;
        map_s2 <= map_s1;
        map_s3 <= map_s2;
        if (!prst_n_p) begin
            map_p <= MAP_RESET;
        end else if (map_s2 == map_s3) begin
            map_p <= map_s3;
        end
    end

    // one input stage on the port's own clock
    always_ff @(posedge pclk) begin
        a_q <= chan_a;
        b_q <= chan_b;
        c_q <= chan_c;
        vs_q <= frame_sync;
        hs_q <= line_sync;
        dv_q <= data_valid;
        vs_d <= vs_q;
        hs_d <= hs_q;
    end

    // sync edges mark the next captured pixel
    always_ff @(posedge pclk) begin
        if (!prst_n_p) begin
            sof_pend <= 1'b0;
            sol_pend <= 1'b0;
            frame_tgl <= 1'b0;
        end else begin
            if (vs_q && !vs_d) begin
                sof_pend <= 1'b1;
                frame_tgl <= ~frame_tgl;
            end else if (dv_q) begin
                sof_pend <= 1'b0;
            end
            if (hs_q && !hs_d) begin
                sol_pend <= 1'b1;
            end else if (dv_q) begin
                sol_pend <= 1'b0;
            end
        end
    end

    // capture only on valid; word held until the next valid pixel
    always_ff @(posedge pclk) begin
        if (!prst_n_p) begin
            hold_pix <= '0;
            hold_sof <= 1'b0;
            hold_sol <= 1'b0;
            hold_tgl <= 1'b0;
        end else if (dv_q) begin
            hold_pix[RED_LSB +: COLOUR_W] <= pick(map_p[RED_SEL_LSB +: SEL_W], a_q, b_q, c_q);
            hold_pix[GREEN_LSB +: COLOUR_W] <= pick(map_p[GREEN_SEL_LSB +: SEL_W], a_q, b_q, c_q);
            hold_pix[BLUE_LSB +: COLOUR_W] <= pick(map_p[BLUE_SEL_LSB +: SEL_W], a_q, b_q, c_q);
            hold_sof <= sof_pend | (vs_q && !vs_d);
            hold_sol <= sol_pend | (hs_q && !hs_d);
            hold_tgl <= ~hold_tgl;
        end
    end

    // ------------------------------------------------------------------
    // system clock domain
    // ------------------------------------------------------------------
    logic ptgl_s1, ptgl_s2, ptgl_s3, ftgl_s1, ftgl_s2, ftgl_s3;
    logic got_data_reg, have_frame_reg;
    logic pix_evt, frm_evt;

    // toggles cross by two flops; the held word is stable by then
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptgl_s1 <= 1'b0;
            ptgl_s2 <= 1'b0;
            ptgl_s3 <= 1'b0;
            ftgl_s1 <= 1'b0;
            ftgl_s2 <= 1'b0;
            ftgl_s3 <= 1'b0;
        end else begin
            ptgl_s1 <= hold_tgl;
            ptgl_s2 <= ptgl_s1;
            ptgl_s3 <= ptgl_s2;
            ftgl_s1 <= frame_tgl;
            ftgl_s2 <= ftgl_s1;
            ftgl_s3 <= ftgl_s2;
        end
    end

    assign pix_evt = ptgl_s2 ^ ptgl_s3;
    assign frm_evt = ftgl_s2 ^ ftgl_s3;

    // pixel word out, one-cycle valid
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pixel_reg <= '0;
            pixel_valid_reg <= 1'b0;
            first_in_line_reg <= 1'b0;
            first_in_frame_reg <= 1'b0;
        end else begin
            pixel_valid_reg <= pix_evt;
            if (pix_evt) begin
                pixel_reg <= hold_pix;
                first_in_line_reg <= hold_sol;
                first_in_frame_reg <= hold_sof;
            end
        end
    end

    // each frame sync judges the interval before it; data arriving at once wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            got_data_reg <= 1'b0;
            have_frame_reg <= 1'b0;
            frame_start_reg <= 1'b0;
            frame_repeat_reg <= 1'b0;
        end else begin
            frame_start_reg <= frm_evt;
            frame_repeat_reg <= frm_evt && have_frame_reg && !got_data_reg;
            if (frm_evt && got_data_reg) begin
                have_frame_reg <= 1'b1;
            end
            if (pix_evt) begin
                got_data_reg <= 1'b1;
            end else if (frm_evt) begin
                got_data_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_word_taken;
        dv_q ##1 1'b1;
    endsequence

    property p_upper_bits;
        @(posedge pclk) disable iff (!prst_n_p)
        (dv_q && map_p == MAP_RESET && $stable(map_p)) |=>
            hold_pix == {$past(a_q[CHAN_W-1:COLOUR_LSB]), $past(b_q[CHAN_W-1:COLOUR_LSB]),
                         $past(c_q[CHAN_W-1:COLOUR_LSB])};
    endproperty

    a_colour_upper_bits: assert property (p_upper_bits)
        else $error("pixel word not taken from upper channel bits");

    a_capture_on_valid: assert property (@(posedge pclk) disable iff (!prst_n_p)
        $changed(hold_tgl) |-> $past(dv_q))
        else $error("pixel captured without data valid");

    a_valid_toggles: assert property (@(posedge pclk) disable iff (!prst_n_p)
        s_word_taken |-> hold_tgl != $past(hold_tgl))
        else $error("valid pixel did not advance the word toggle");

    a_frame_mark: assert property (@(posedge pclk) disable iff (!prst_n_p)
        (vs_q && !vs_d && dv_q) |=> hold_sof)
        else $error("first pixel of frame not marked");

    a_word_delivered: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(ptgl_s2) |=> pixel_valid_reg ##1 !pixel_valid_reg)
        else $error("crossed word not presented as a one-cycle valid");

    a_repeat_at_sync: assert property (@(posedge clk) disable iff (!rst_n)
        frame_repeat_reg |-> frame_start_reg && !$past(got_data_reg))
        else $error("frame repeat without an empty frame interval");

    a_empty_frame_repeats: assert property (@(posedge clk) disable iff (!rst_n)
        (frm_evt && have_frame_reg && !got_data_reg) |=> frame_repeat_reg)
        else $error("empty frame interval not repeated");
endmodule // rgb_port_rx

module dual_rgb_input
    import dual_rgb_pkg::*;
#(
    parameter int CLK3_TIMEOUT = dual_rgb_pkg::CLK3_TIMEOUT_CYC
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    // channel maps, quasi-static
    input wire logic [dual_rgb_pkg::MAP_W-1:0] port1_colour_map,
    input wire logic [dual_rgb_pkg::MAP_W-1:0] port2_colour_map,
    // port 1 pins
    input wire logic port1_pixel_clock,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] port1_colour_data_a,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] port1_colour_data_b,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] port1_colour_data_c,
    input wire logic port1_frame_sync,
    input wire logic port1_line_sync,
    input wire logic port1_data_valid,
    // port 2 pins
    input wire logic port2_pixel_clock,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] port2_colour_data_a,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] port2_colour_data_b,
    input wire logic [dual_rgb_pkg::CHAN_W-1:0] port2_colour_data_c,
    input wire logic port2_frame_sync,
    input wire logic port2_line_sync,
    input wire logic port2_data_valid,
    // optional third clock
    input wire logic optional_third_pixel_clock,
    // port 1 stream
    output dual_rgb_pkg::pixel_t port1_pixel,
    output logic port1_pixel_valid,
    output logic port1_first_in_line,
    output logic port1_first_in_frame,
    output logic port1_frame_start,
    output logic port1_frame_repeat,
    // port 2 stream
    output dual_rgb_pkg::pixel_t port2_pixel,
    output logic port2_pixel_valid,
    output logic port2_first_in_line,
    output logic port2_first_in_frame,
    output logic port2_frame_start,
    output logic port2_frame_repeat,
    // status
    output logic third_clock_active
);
    // ------------------------------------------------------------------
    // the two pixel ports
    // ------------------------------------------------------------------
    rgb_port_rx u_port1 (
        .clk(clk), .rst_n(rst_n), .colour_map(port1_colour_map),
        .pclk(port1_pixel_clock), .chan_a(port1_colour_data_a),
        .chan_b(port1_colour_data_b), .chan_c(port1_colour_data_c),
        .frame_sync(port1_frame_sync), .line_sync(port1_line_sync),
        .data_valid(port1_data_valid), .pixel_reg(port1_pixel),
        .pixel_valid_reg(port1_pixel_valid), .first_in_line_reg(port1_first_in_line),
        .first_in_frame_reg(port1_first_in_frame), .frame_start_reg(port1_frame_start),
        .frame_repeat_reg(port1_frame_repeat)
    );

    rgb_port_rx u_port2 (
        .clk(clk), .rst_n(rst_n), .colour_map(port2_colour_map),
        .pclk(port2_pixel_clock), .chan_a(port2_colour_data_a),
        .chan_b(port2_colour_data_b), .chan_c(port2_colour_data_c),
        .frame_sync(port2_frame_sync), .line_sync(port2_line_sync),
        .data_valid(port2_data_valid), .pixel_reg(port2_pixel),
        .pixel_valid_reg(port2_pixel_valid), .first_in_line_reg(port2_first_in_line),
        .first_in_frame_reg(port2_first_in_frame), .frame_start_reg(port2_frame_start),
        .frame_repeat_reg(port2_frame_repeat)
    );

    // ------------------------------------------------------------------
    // third clock presence monitor
    // ------------------------------------------------------------------
    logic c3_rst_s1, c3_rst_n, c3_tgl;
    logic c3_s1, c3_s2, c3_s3;
    logic [CLK3_CNT_W-1:0] c3_idle_reg;

    // divide clock 3 down to a toggle; reset follows rst_n onto it
    always_ff @(posedge optional_third_pixel_clock) begin
        c3_rst_s1 <= rst_n;
        c3_rst_n <= c3_rst_s1;
        if (!c3_rst_n) begin
            c3_tgl <= 1'b0;
        end else begin
            c3_tgl <= ~c3_tgl;
        end
    end

    // idle counter restarts on each crossed toggle edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c3_s1 <= 1'b0;
            c3_s2 <= 1'b0;
            c3_s3 <= 1'b0;
            c3_idle_reg <= CLK3_CNT_W'(CLK3_TIMEOUT);
            third_clock_active <= 1'b0;
        end else begin
            c3_s1 <= c3_tgl;
            c3_s2 <= c3_s1;
            c3_s3 <= c3_s2;
            if (c3_s2 ^ c3_s3) begin
                c3_idle_reg <= '0;
            end else if (c3_idle_reg != CLK3_CNT_W'(CLK3_TIMEOUT)) begin
                c3_idle_reg <= c3_idle_reg + 1'b1;
            end
            third_clock_active <= (c3_s2 ^ c3_s3) ||
                (c3_idle_reg < CLK3_CNT_W'(CLK3_TIMEOUT - 1));
        end
    end

    // a toggle edge that lands on the timeout cycle legally revives the flag
    a_clock3_absent: assert property (@(posedge clk) disable iff (!rst_n)
        (c3_idle_reg == CLK3_CNT_W'(CLK3_TIMEOUT) && !(c3_s2 ^ c3_s3))
            |=> !third_clock_active)
        else $error("clock 3 reported active after timeout");
endmodule // dual_rgb_input

// [hdl/dual_rgb_pkg.sv]
// constants shared by the dual parallel rgb video input
// assumes a 200 MHz system clock; pixel clocks are separate and unrelated
package dual_rgb_pkg;
    // ------------------------------------------------------------------
    // pixel bus layout
    // ------------------------------------------------------------------
    localparam int CHAN_W = 10;                      // width of each input channel
    localparam int COLOUR_W = 8;                     // significant bits per colour
    localparam int COLOUR_LSB = CHAN_W - COLOUR_W;   // colour sits in the upper bits
    localparam int PIXEL_W = 3 * COLOUR_W;           // 24-bit pixel word
    localparam int RED_LSB = 2 * COLOUR_W;
    localparam int GREEN_LSB = COLOUR_W;
    localparam int BLUE_LSB = 0;

    // ------------------------------------------------------------------
    // channel reassignment map: one select per colour
    // ------------------------------------------------------------------
    localparam int SEL_W = 2;
    localparam int MAP_W = 3 * SEL_W;
    localparam int RED_SEL_LSB = 2 * SEL_W;
    localparam int GREEN_SEL_LSB = SEL_W;
    localparam int BLUE_SEL_LSB = 0;
    localparam logic [SEL_W-1:0] SEL_A = 2'h0;
    localparam logic [SEL_W-1:0] SEL_B = 2'h1;
    localparam logic [SEL_W-1:0] SEL_C = 2'h2;
    localparam logic [MAP_W-1:0] MAP_RESET = 6'h06; // red=a, green=b, blue=c

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK3_TIMEOUT_NS = 1000;           // silence before clock 3 counts as absent
    localparam int CLK3_TIMEOUT_CYC = (CLK3_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK3_CNT_W = 8;

    typedef logic [PIXEL_W-1:0] pixel_t;
    typedef logic [CHAN_W-1:0] chan_t;
endpackage

// [verif/video_source.sv]
// behavioural pixel source for one rgb input port
// assumes the bench calls send_frame; the pixel clock runs free so syncs can flow
`timescale 1ns/10ps

module video_source #(
    parameter realtime PHASE = 0.0
) (
    // pixel link
    output logic pclk,
    output logic [9:0] chan_a,
    output logic [9:0] chan_b,
    output logic [9:0] chan_c,
    output logic frame_sync,
    output logic line_sync,
    output logic data_valid
);
    // ------------------------------------------------------------------
    // pixel clock and idle levels
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        {chan_a, chan_b, chan_c} = 30'h0;
        {frame_sync, line_sync, data_valid} = 3'h0;
        #PHASE;
        forever #62.5 pclk = ~pclk;
    end

    // launch one step just after the pixel clock edge
    task automatic step();
        @(posedge pclk);
        #1;
    endtask

    // idle data shows the inverse of the last word, never a stale copy
    task automatic blank();
        data_valid = 1'b0;
        {chan_a, chan_b, chan_c} = ~{chan_a, chan_b, chan_c};
    endtask

    // ------------------------------------------------------------------
    // one frame: frame sync, line sync, n words; syncs sent even when empty
    // ------------------------------------------------------------------
    task automatic send_frame(input logic [7:0] seed, input int n, input bit with_data,
                              input bit gaps);
        logic [7:0] b;
        step();
        frame_sync = 1'b1;
        step();
        frame_sync = 1'b0;
        line_sync = 1'b1;
        step();
        line_sync = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (gaps) begin
                blank();
                step();
            end
            b = seed + 8'(i);
            // colour in the upper bits, junk below it
            chan_a = {b, 2'b01};
            chan_b = {b + 8'h40, 2'b10};
            chan_c = {~b, 2'b11};
            data_valid = with_data;
            step();
        end
        blank();
        repeat (4) step();
    endtask
endmodule // video_source

// [verif/dual_rgb_input_tb.sv]
// self-checking bench for the dual rgb input, two behavioural sources
// assumes 200 MHz clk and 125 ns pixel clocks of unrelated phase
`timescale 1ns/10ps

module dual_rgb_input_tb;
    import dual_rgb_pkg::*;
    logic clk, rst_n, c3, c3_run;
    logic [MAP_W-1:0] map1, map2;
    logic pc1, pc2, fs1, fs2, ls1, ls2, dv1, dv2;
    logic [CHAN_W-1:0] a1, b1, cc1, a2, b2, cc2;
    pixel_t pix1, pix2;
    logic pv1, pv2, fil1, fil2, fif1, fif2, st1, st2, rp1, rp2, c3_act;
    pixel_t q1[$], q2[$];
    int fif[2], fil[2], fst[2], rep[2];
    int error_cnt = 0;
    int n_tests = 0;

    // ------------------------------------------------------------------
    // clocks, sources and design
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // third clock toggles only while c3_run is set
    initial begin
        c3 = 1'b0;
        forever #62.5 c3 = c3_run ? ~c3 : c3;
    end
    video_source #(.PHASE(0.0)) src1_i (.pclk(pc1), .chan_a(a1), .chan_b(b1), .chan_c(cc1),
        .frame_sync(fs1), .line_sync(ls1), .data_valid(dv1));
    video_source #(.PHASE(37.3)) src2_i (.pclk(pc2), .chan_a(a2), .chan_b(b2), .chan_c(cc2),
        .frame_sync(fs2), .line_sync(ls2), .data_valid(dv2));
    dual_rgb_input #(.CLK3_TIMEOUT(60)) dual_rgb_input_i (.clk(clk), .rst_n(rst_n),
        .port1_colour_map(map1), .port2_colour_map(map2),
        .port1_pixel_clock(pc1), .port1_colour_data_a(a1), .port1_colour_data_b(b1),
        .port1_colour_data_c(cc1), .port1_frame_sync(fs1), .port1_line_sync(ls1),
        .port1_data_valid(dv1), .port2_pixel_clock(pc2), .port2_colour_data_a(a2),
        .port2_colour_data_b(b2), .port2_colour_data_c(cc2), .port2_frame_sync(fs2),
        .port2_line_sync(ls2), .port2_data_valid(dv2), .optional_third_pixel_clock(c3),
        .port1_pixel(pix1), .port1_pixel_valid(pv1), .port1_first_in_line(fil1),
        .port1_first_in_frame(fif1), .port1_frame_start(st1), .port1_frame_repeat(rp1),
        .port2_pixel(pix2), .port2_pixel_valid(pv2), .port2_first_in_line(fil2),
        .port2_first_in_frame(fif2), .port2_frame_start(st2), .port2_frame_repeat(rp2),
        .third_clock_active(c3_act));

    // collect received words and event counts
    always @(posedge clk) begin
        if (pv1 === 1'b1) begin
            q1.push_back(pix1);
            fif[0] += int'(fif1 === 1'b1);
            fil[0] += int'(fil1 === 1'b1);
        end
        if (pv2 === 1'b1) begin
            q2.push_back(pix2);
            fif[1] += int'(fif2 === 1'b1);
            fil[1] += int'(fil2 === 1'b1);
        end
        fst[0] += int'(st1 === 1'b1);
        fst[1] += int'(st2 === 1'b1);
        rep[0] += int'(rp1 === 1'b1);
        rep[1] += int'(rp2 === 1'b1);
    end

    // ------------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // expected word for a source seed, index and colour map (codes 0 and 3 pick a)
    function automatic pixel_t exp_pix(input logic [7:0] s, input int i, input logic [5:0] m);
        logic [7:0] v[4];
        v[0] = s + 8'(i);
        v[1] = v[0] + 8'h40;
        v[2] = ~v[0];
        v[3] = v[0];
        return {v[m[5:4]], v[m[3:2]], v[m[1:0]]};
    endfunction

    task automatic wait_for(input int n, input int f0, input bit pixels);
        int k;
        for (k = 0; k < 3000; k++) begin
            if (pixels ? (q1.size() >= n && q2.size() >= n) : fst[0] >= f0)
                break;
            @(posedge clk);
        end
        repeat (8) @(posedge clk);
        if (k == 3000) begin
            chk("wait timeout", 32'h1, 32'h0);
            report_and_stop();
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // both ports at once, maps changed while idle, optional gaps in data valid
    task automatic t_pixels(input logic [5:0] m1, input logic [5:0] m2, input int n,
                            input bit gaps);
        int f1, f2, l1, l2;
        @(posedge clk);
        #1;
        map1 = m1;
        map2 = m2;
        repeat (8) @(posedge pc1);
        q1.delete();
        q2.delete();
        {f1, f2, l1, l2} = {fif[0], fif[1], fil[0], fil[1]};
        fork
            src1_i.send_frame(8'h10, n, 1'b1, gaps);
            src2_i.send_frame(8'hc7, n, 1'b1, gaps);
        join
        wait_for(n, 0, 1'b1);
        chk("count p1", q1.size(), n);
        chk("count p2", q2.size(), n);
        for (int i = 0; i < n; i++) begin
            chk("pixel p1", q1[i], exp_pix(8'h10, i, m1));
            chk("pixel p2", q2[i], exp_pix(8'hc7, i, m2));
        end
        chk("first frame p1", fif[0] - f1, 1);
        chk("first frame p2", fif[1] - f2, 1);
        chk("first line p1", fil[0] - l1, 1);
        chk("first line p2", fil[1] - l2, 1);
    endtask

    // data frame then two empty intervals: only the start after an empty one repeats
    task automatic t_repeat();
        int s0, r0, s1;
        {s0, r0, s1} = {fst[0], rep[0], fst[1]};
        src1_i.send_frame(8'h55, 3, 1'b1, 1'b0);
        src1_i.send_frame(8'h00, 3, 1'b0, 1'b0);
        src1_i.send_frame(8'h00, 3, 1'b0, 1'b0);
        wait_for(0, s0 + 3, 1'b0);
        chk("frame starts", fst[0] - s0, 3);
        chk("repeats", rep[0] - r0, 1);
        chk("port2 quiet", fst[1] - s1, 0);
        // port 2 ended on a data frame; only its first empty interval repeats, at the second sync
        {s1, r0} = {fst[1], rep[1]};
        src2_i.send_frame(8'h00, 2, 1'b0, 1'b0);
        src2_i.send_frame(8'h00, 2, 1'b0, 1'b0);
        repeat (8) @(posedge clk);
        chk("port2 starts", fst[1] - s1, 2);
        chk("port2 repeats", rep[1] - r0, 1);
    endtask

    // third clock seen while running, dropped after it stops
    task automatic t_clock3();
        int k;
        chk("c3 idle", c3_act, 1'b0);
        c3_run = 1'b1;
        for (k = 0; k < 400 && c3_act !== 1'b1; k++)
            @(posedge clk);
        chk("c3 active", c3_act, 1'b1);
        c3_run = 1'b0;
        for (k = 0; k < 400 && c3_act !== 1'b0; k++)
            @(posedge clk);
        chk("c3 stopped", c3_act, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        // clock 3 runs through reset so its toggle starts known, then stops
        c3_run = 1'b1;
        map1 = 6'h06;
        map2 = 6'h06;
        // reset must span several pixel clocks to reach the pixel domains
        repeat (4) @(posedge pc1);
        c3_run = 1'b0;
        chk("reset outputs", {pv1, pv2, st1, st2, c3_act}, 5'h0);
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge pc1);
        t_pixels(6'h06, 6'h06, 5, 1'b0);
        t_pixels(6'h21, 6'h39, 4, 1'b1);
        t_repeat();
        t_clock3();
        report_and_stop();
    end
endmodule // dual_rgb_input_tb
